/* File: rtl/mdl_defines.vh */
`ifndef MDL_DEFINES_VH
`define MDL_DEFINES_VH
`define MDL_REG_HEADER 8'h04
`define MDL_REG_PAYLOAD 8'h05
`define MDL_REG_STATUS 8'h02
`define MDL_HDR_ID 16'h001f
`define MDL_SEL_CPU_PROG 8'h00
`define MDL_SEL_CPU_XDATA 8'h01
`define MDL_SEL_DSP_PROG 8'h02
`define MDL_SEL_DSP_COEF 8'h03
`define MDL_SEL_DSP_DATA 8'h04
`define MDL_HDR_BYTES 16'h000c
`define MDL_TRL_BYTES 16'h0004
`define MDL_ERR_INVALID_SEL 6
`define MDL_ERR_END_HDR 7
`define MDL_STATUS_RESET 8'h00
`define MDL_BUF_DEPTH 2
`endif

/* File: rtl/mdl_loader.v */
`timescale 1ns/1ps
`include "mdl_defines.vh"
module mdl_loader (
  input wire clk_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [63:0] reg_wdata_i,
  output reg [63:0] reg_rdata_o,
  input wire [7:0] stream_byte_i,
  input wire stream_valid_i,
  output wire stream_ready_o,
  output wire [2:0] mem_sel_o,
  output wire [15:0] mem_addr_o,
  output wire [55:0] mem_data_o,
  output wire mem_valid_o,
  input wire mem_ready_i,
  output reg session_done_o,
  output wire busy_o
);
  localparam S_IDLE = 4'b0001;
  localparam S_SLAVE = 4'b0010;
  localparam S_STREAM = 4'b0100;
  localparam S_DONE = 4'b1000;

  reg rst_m;
  reg rst_q;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end

  reg [3:0] state;
  reg [7:0] err_flags;
  reg [15:0] hdr_sum;
  reg [15:0] hdr_id;
  reg [7:0] sel;
  reg [15:0] addr;
  reg [15:0] total;
  reg [15:0] pos;
  reg [15:0] calc_sum;
  reg [15:0] tail_sum;
  reg [55:0] acc;
  reg [2:0] acc_cnt;
  reg bad;
  reg slave_mode;
  reg [63:0] hdr_reg;
  reg [63:0] pay_reg;

  reg [74:0] push_data;
  reg push_valid;
  wire push_ready;
  wire [74:0] pop_data;

  mdl_word_buf u_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_q),
    .in_data_i(push_data),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .out_data_o(pop_data),
    .out_valid_o(mem_valid_o),
    .out_ready_i(mem_ready_i)
  );
  assign mem_sel_o = pop_data[74:72];
  assign mem_addr_o = pop_data[71:56];
  assign mem_data_o = pop_data[55:0];
  assign busy_o = (state != S_IDLE) && (state != S_DONE);

  // Bytes per stored word for each memory
  function [2:0] word_len;
    input [7:0] s;
    begin
      case (s)
        `MDL_SEL_DSP_PROG: word_len = 3'd7;
        `MDL_SEL_DSP_COEF: word_len = 3'd4;
        `MDL_SEL_DSP_DATA: word_len = 3'd6;
        default: word_len = 3'd1;
      endcase
    end
  endfunction

  function [15:0] bsum;
    input [63:0] w;
    input [3:0] n;
    integer k;
    begin
      bsum = 16'd0;
      for (k = 0; k < 8; k = k + 1)
        if (k < n)
          bsum = bsum + {8'd0, w[63 - k*8 -: 8]};
    end
  endfunction

  wire sel_ok = (sel <= `MDL_SEL_DSP_DATA);
  wire [2:0] err_bit = (sel == `MDL_SEL_CPU_XDATA) ? 3'd1 : sel[2:0];
  wire hdr_wr = reg_wr_i && reg_addr_i == `MDL_REG_HEADER;
  wire pay_wr = reg_wr_i && reg_addr_i == `MDL_REG_PAYLOAD;
  wire st_wr = reg_wr_i && reg_addr_i == `MDL_REG_STATUS;
  wire [15:0] data_end = total - `MDL_TRL_BYTES;
  wire byte_take = (state == S_STREAM) && stream_valid_i && push_ready;
  // Idle and done both accept a first stream byte, so both must show ready
  assign stream_ready_o = (state != S_SLAVE) && push_ready;
  wire pay_ready = push_ready;
  // Last slave payload is the group that reaches the block's total length
  wire [15:0] pay_next = pos + 16'd8;
  wire pay_last = (pay_next >= total);

  reg [7:0] next_err;
  always @* begin
    next_err = err_flags;
    if (st_wr)
      next_err = reg_wdata_i[39:32];
  end

  // Closing result for a block; it wins over a simultaneous status write to that bit, whether it sets or clears
  task finish;
    input [15:0] trail;
    input [15:0] sumv;
    begin
      if (bad || trail != hdr_sum || sumv != hdr_sum)
        err_flags <= next_err | (8'd1 << err_bit);
      else
        err_flags <= next_err & ~(8'd1 << err_bit);
    end
  endtask

  always @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      state <= S_IDLE;
      err_flags <= `MDL_STATUS_RESET;
      hdr_sum <= 16'd0;
      hdr_id <= 16'd0;
      sel <= 8'd0;
      addr <= 16'd0;
      total <= 16'd0;
      pos <= 16'd0;
      calc_sum <= 16'd0;
      tail_sum <= 16'd0;
      acc <= 56'd0;
      acc_cnt <= 3'd0;
      bad <= 1'b0;
      slave_mode <= 1'b0;
      hdr_reg <= 64'd0;
      pay_reg <= 64'd0;
      push_data <= 75'd0;
      push_valid <= 1'b0;
      session_done_o <= 1'b0;
    end else begin
      err_flags <= next_err;
      session_done_o <= 1'b0;
      if (push_valid && push_ready)
        push_valid <= 1'b0;
      case (state)
        S_IDLE, S_DONE: begin
          if (hdr_wr) begin
            hdr_reg <= reg_wdata_i;
            hdr_sum <= reg_wdata_i[63:48];
            sel <= reg_wdata_i[47:40];
            addr <= reg_wdata_i[31:16];
            total <= reg_wdata_i[15:0];
            // Sum starts past the checksum; the implied identifier bytes count too
            calc_sum <= bsum({16'd0, reg_wdata_i[47:0]}, 4'd8) + `MDL_HDR_ID;
            pos <= `MDL_HDR_BYTES;
            slave_mode <= 1'b1;
            bad <= (reg_wdata_i[47:40] > `MDL_SEL_DSP_DATA);
            if (reg_wdata_i[15:0] == 16'd0) begin
              state <= S_DONE;
              session_done_o <= 1'b1;
              if (reg_wdata_i != 64'd0)
                err_flags <= next_err | (8'd1 << `MDL_ERR_END_HDR);
            end else if (reg_wdata_i[47:40] > `MDL_SEL_DSP_DATA) begin
              state <= S_IDLE;
              err_flags <= next_err | (8'd1 << `MDL_ERR_INVALID_SEL);
            end else begin
              state <= S_SLAVE;
            end
          end else if (stream_valid_i && push_ready) begin
            state <= S_STREAM;
            slave_mode <= 1'b0;
            pos <= 16'd1;
            hdr_sum <= {stream_byte_i, 8'd0};
            calc_sum <= 16'd0;
            bad <= 1'b0;
            acc_cnt <= 3'd0;
          end
        end
        S_SLAVE: begin
          if (hdr_wr) begin
            bad <= 1'b1;
            state <= S_IDLE;
            err_flags <= next_err | (8'd1 << err_bit);
          end else if (pay_wr && pay_ready && !push_valid) begin
            pay_reg <= reg_wdata_i;
            pos <= pay_next;
            if (pay_last) begin
              finish(reg_wdata_i[15:0], calc_sum + bsum(reg_wdata_i, 4'd6));
              if (reg_wdata_i[31:16] != 16'd0)
                err_flags <= next_err | (8'd1 << err_bit);
              state <= S_IDLE;
            end else begin
              calc_sum <= calc_sum + bsum(reg_wdata_i, 4'd8);
              push_valid <= sel_ok;
              case (sel)
                `MDL_SEL_DSP_PROG: begin
                  push_data <= {sel[2:0], addr, reg_wdata_i[55:0]};
                  addr <= addr + 16'd1;
                end
                `MDL_SEL_DSP_COEF: begin
                  push_data <= {sel[2:0], addr, 24'd0, reg_wdata_i[63:32]};
                  addr <= addr + 16'd1;
                end
                `MDL_SEL_DSP_DATA: begin
                  push_data <= {sel[2:0], addr, 8'd0, reg_wdata_i[47:0]};
                  addr <= addr + 16'd1;
                end
                default: begin
                  // Controller groups push only their top seven bytes; the address still steps by eight
                  push_data <= {sel[2:0], addr, reg_wdata_i[63:8]};
                  addr <= addr + 16'd8;
                end
              endcase
            end
          end
        end
        S_STREAM: begin
          if (byte_take) begin
            pos <= pos + 16'd1;
            if (pos >= 16'd2 && pos < total - 16'd2)
              calc_sum <= calc_sum + {8'd0, stream_byte_i};
            case (pos)
              16'd1: hdr_sum <= {hdr_sum[15:8], stream_byte_i};
              16'd2: hdr_id[15:8] <= stream_byte_i;
              16'd3: hdr_id[7:0] <= stream_byte_i;
              16'd4: sel <= stream_byte_i;
              16'd6: addr[15:8] <= stream_byte_i;
              16'd7: addr[7:0] <= stream_byte_i;
              16'd8: total[15:8] <= stream_byte_i;
              16'd9: total[7:0] <= stream_byte_i;
              16'd11: begin
                if (hdr_id != `MDL_HDR_ID)
                  bad <= 1'b1;
                if (!sel_ok) begin
                  bad <= 1'b1;
                  err_flags <= next_err | (8'd1 << `MDL_ERR_INVALID_SEL);
                end
                if (total == 16'd0) begin
                  state <= S_DONE;
                  session_done_o <= 1'b1;
                end
              end
              default: begin
                if (pos >= `MDL_HDR_BYTES && pos < data_end) begin
                  acc[acc_cnt*8 +: 8] <= stream_byte_i;
                  if (acc_cnt == word_len(sel) - 3'd1) begin
                    acc_cnt <= 3'd0;
                    push_valid <= sel_ok;
                    // One-byte words must not carry bytes left from an older word
                    push_data <= {sel[2:0], addr, (acc_cnt == 3'd0) ? 56'd0 : acc};
                    push_data[acc_cnt*8 +: 8] <= stream_byte_i;
                    addr <= addr + 16'd1;
                  end else begin
                    acc_cnt <= acc_cnt + 3'd1;
                    if (acc_cnt == 3'd0)
                      acc <= {48'd0, stream_byte_i};
                  end
                end else if (pos == data_end || pos == data_end + 16'd1) begin
                  if (stream_byte_i != 8'd0)
                    bad <= 1'b1;
                end else if (pos == total - 16'd2) begin
                  tail_sum[15:8] <= stream_byte_i;
                end else if (pos == total - 16'd1) begin
                  finish({tail_sum[15:8], stream_byte_i}, calc_sum);
                  state <= S_IDLE;
                end
              end
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_q) begin
    if (!rst_q)
      reg_rdata_o <= 64'd0;
    else if (reg_addr_i == `MDL_REG_STATUS)
      reg_rdata_o <= {24'd0, err_flags, 32'd0};
    else if (reg_addr_i == `MDL_REG_HEADER)
      reg_rdata_o <= hdr_reg;
    else if (reg_addr_i == `MDL_REG_PAYLOAD)
      reg_rdata_o <= pay_reg;
    else
      reg_rdata_o <= 64'd0;
  end
endmodule // mdl_loader

/* File: rtl/mdl_word_buf.v */
`timescale 1ns/1ps
// Two-entry buffer; a stall downstream holds words instead of dropping them
module mdl_word_buf (
  input wire clk_i,
  input wire rst_b_i,
  input wire [74:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output reg [74:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [74:0] spare;
  reg [1:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != 2'd2);
  assign out_valid_o = (count != 2'd0);
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 2'd0;
      spare <= 75'd0;
      out_data_o <= 75'd0;
    end else begin
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
      if (pop) begin
        if (count == 2'd2)
          out_data_o <= spare;
        else if (push)
          out_data_o <= in_data_i;
      end else if (push) begin
        if (count == 2'd0)
          out_data_o <= in_data_i;
        else
          spare <= in_data_i;
      end
      if (pop && push && count == 2'd2)
        spare <= in_data_i;
    end
  end
endmodule // mdl_word_buf

/* File: test/mdl_ext_mem.sv */
`timescale 1ns/1ps
// Boot memory streaming an image, and a RAM sink that may stall
module mdl_ext_mem (
  input wire clk_i,
  input wire rst_b_i,
  input wire go_i,
  input wire [7:0] len_i,
  input wire stall_i,
  output wire [7:0] stream_byte_o,
  output wire stream_valid_o,
  input wire stream_ready_i,
  input wire [2:0] mem_sel_i,
  input wire [15:0] mem_addr_i,
  input wire [55:0] mem_data_i,
  input wire mem_valid_i,
  output wire mem_ready_o,
  output reg [7:0] words_o,
  output reg [74:0] last_o
);
  reg [7:0] img [0:255];
  reg [7:0] pos;
  reg [7:0] len;
  reg run;
  reg ph;
  assign stream_valid_o = run;
  // Idle line shows the inverse of the last byte so a stale sample is caught
  assign stream_byte_o = run ? img[pos] : ~img[pos - 8'h01];
  assign mem_ready_o = ~(stall_i & ph);
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run <= 1'b0;
      pos <= 8'h00;
      len <= 8'h00;
      ph <= 1'b0;
      words_o <= 8'h00;
      last_o <= 75'h0;
    end else begin
      ph <= ~ph;
      if (go_i) begin
        run <= 1'b1;
        pos <= 8'h00;
        len <= len_i;
      end else if (run && stream_ready_i) begin
        pos <= pos + 8'h01;
        run <= (pos + 8'h01 != len);
      end
      if (mem_valid_i && mem_ready_o) begin
        words_o <= words_o + 8'h01;
        last_o <= {mem_sel_i, mem_addr_i, mem_data_i};
      end
    end
  end
endmodule // mdl_ext_mem

/* File: test/mdl_loader_assertions.sv */
`timescale 1ns/1ps
module mdl_loader_assertions (
  input wire clk_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [63:0] reg_wdata_i,
  input wire [2:0] mem_sel_o,
  input wire [15:0] mem_addr_o,
  input wire [55:0] mem_data_o,
  input wire mem_valid_o,
  input wire mem_ready_i,
  input wire session_done_o,
  input wire busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire hdr_wr = reg_wr_i && reg_addr_i == 8'h04;
  mem_hold_a: assert property (
    mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable({mem_sel_o, mem_addr_o, mem_data_o}))
    else $error("ram word changed while stalled");
  done_pulse_a: assert property (session_done_o |=> !session_done_o)
    else $error("end pulse too long");
  done_quiet_a: assert property (session_done_o |-> !mem_valid_o)
    else $error("ram write on end header");
  term_done_a: assert property (
    hdr_wr && reg_wdata_i == 64'h0 |-> ##[1:3] session_done_o)
    else $error("end header not seen");
  sel_range_a: assert property (mem_valid_o |-> mem_sel_o <= 3'h4)
    else $error("ram write to reserved select");
  coef_width_a: assert property (
    mem_valid_o && mem_sel_o == 3'h3 |-> mem_data_o[55:32] == 24'h0)
    else $error("coefficient too wide");
  data_width_a: assert property (
    mem_valid_o && mem_sel_o == 3'h4 |-> mem_data_o[55:48] == 8'h0)
    else $error("data word too wide");
  hdr_busy_a: assert property (
    hdr_wr && reg_wdata_i[15:0] != 16'h0 && reg_wdata_i[47:40] < 8'h05 |-> ##[1:2] busy_o)
    else $error("header did not start a block");
  cover property (mem_valid_o && !mem_ready_i);
  cover property (session_done_o);
  cover property (mem_valid_o && mem_sel_o == 3'h2);
endmodule // mdl_loader_assertions

bind mdl_loader mdl_loader_assertions mdl_loader_assertions_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .mem_sel_o(mem_sel_o), .mem_addr_o(mem_addr_o),
  .mem_data_o(mem_data_o), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
  .session_done_o(session_done_o), .busy_o(busy_o)
);

/* File: test/mdl_loader_test.sv */
`timescale 1ns/1ps
module mdl_loader_test;
  reg clk_i;
  reg rst_b_i;
  reg [7:0] reg_addr_i;
  reg reg_wr_i;
  reg [63:0] reg_wdata_i;
  reg go;
  reg [7:0] len;
  reg stall;
  wire [63:0] reg_rdata_o;
  wire [7:0] sb;
  wire sv, sr, mv, mr, sd, busy;
  wire [2:0] ms;
  wire [15:0] ma;
  wire [55:0] md;
  wire [7:0] words;
  wire [74:0] last;
  reg [7:0] im [0:31];
  reg [63:0] st;
  integer num_errors, n_tests, cyc, j, k;
  mdl_loader mdl_loader_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .stream_byte_i(sb),
    .stream_valid_i(sv), .stream_ready_o(sr), .mem_sel_o(ms), .mem_addr_o(ma),
    .mem_data_o(md), .mem_valid_o(mv), .mem_ready_i(mr), .session_done_o(sd), .busy_o(busy)
  );
  mdl_ext_mem mdl_ext_mem_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .len_i(len), .stall_i(stall),
    .stream_byte_o(sb), .stream_valid_o(sv), .stream_ready_i(sr), .mem_sel_i(ms),
    .mem_addr_i(ma), .mem_data_i(md), .mem_valid_i(mv), .mem_ready_o(mr),
    .words_o(words), .last_o(last)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  task chk(input [74:0] got, input [74:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Idle cycle after each write so the strobe never toggles twice in one step
  task wr(input [7:0] a, input [63:0] d);
    begin
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(posedge clk_i);
      #1 reg_wr_i = 1'b0;
      @(posedge clk_i);
      #1;
    end
  endtask
  task rd(input [7:0] a);
    begin
      reg_addr_i = a;
      repeat (2) @(posedge clk_i);
      #1 st = reg_rdata_o;
    end
  endtask
  task settle(input b);
    begin
      repeat (3) @(posedge clk_i);
      #1 k = 0;
      while ((mv || sv || (b && busy)) && k < 100) begin
        @(posedge clk_i);
        #1 k = k + 1;
      end
      chk(k < 100, 1'b1);
    end
  endtask
  task t_reset;
    begin
      rd(8'h02);
      chk(st, 64'h0);
      chk({sd, busy, mv}, 3'h0);
      $display("reset test done");
    end
  endtask
  task t_badsel;
    begin
      for (j = 5; j < 16; j = j + 10) begin
        wr(8'h04, {16'h0, j[7:0], 8'h00, 16'h0040, 16'h0018});
        rd(8'h02);
        chk(st[39:32], 8'h40);
        wr(8'h02, 64'h0);
        rd(8'h02);
        chk(st[39:32], 8'h00);
      end
      $display("select test done");
    end
  endtask
  task t_master(input [2:0] s, input [3:0] nb, input [55:0] w, input bad, input [7:0] es);
    reg [15:0] cs;
    reg [7:0] c0;
    begin
      c0 = words;
      for (j = 0; j < 32; j = j + 1) im[j] = 8'h00;
      im[3] = 8'h1f;
      im[4] = {5'h0, s};
      im[7] = 8'h20;
      im[9] = 8'd16 + nb;
      for (j = 0; j < nb; j = j + 1) im[12 + j] = w[8 * j +: 8];
      cs = {15'h0, bad};
      for (j = 2; j < 12 + nb; j = j + 1) cs = cs + im[j];
      {im[0], im[1]} = cs;
      {im[14 + nb], im[15 + nb]} = cs;
      for (j = 0; j < 32; j = j + 1) mdl_ext_mem_i.img[j] = im[j];
      len = 8'd16 + nb;
      go = 1'b1;
      @(posedge clk_i);
      #1 go = 1'b0;
      settle(1'b1);
      rd(8'h02);
      chk(st[39:32], es);
      if (!bad) chk(last, {s, 16'h0020, w});
      if (!bad) chk(words, c0 + 8'h01);
      $display("stream test done");
    end
  endtask
  task t_slave(input [2:0] s, input [63:0] p, input [55:0] w);
    reg [7:0] c0;
    reg [15:0] cs;
    begin
      c0 = words;
      cs = 16'h001f + {13'h0, s} + 16'h0040 + 16'h0018;
      for (j = 0; j < 8; j = j + 1) cs = cs + {8'h00, p[8 * j +: 8]};
      wr(8'h04, {cs, 5'h0, s, 8'h00, 16'h0040, 16'h0018});
      wr(8'h05, p);
      settle(1'b0);
      chk(last, {s, 16'h0040, w});
      chk(words, c0 + 8'h01);
      wr(8'h05, {48'h0, cs});
      settle(1'b1);
      chk(words, c0 + 8'h01);
      rd(8'h02);
      chk(st[39:32], 8'h00);
      $display("register test done");
    end
  endtask
  task t_term;
    reg [7:0] c0;
    begin
      c0 = words;
      reg_addr_i = 8'h04;
      reg_wdata_i = 64'h0;
      reg_wr_i = 1'b1;
      @(posedge clk_i);
      #1 reg_wr_i = 1'b0;
      for (j = 0; j < 4 && sd !== 1'b1; j = j + 1) begin
        @(posedge clk_i);
        #1;
      end
      chk(sd, 1'b1);
      repeat (4) @(posedge clk_i);
      #1 chk(words, c0);
      $display("end test done");
    end
  endtask
  initial begin
    rst_b_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 64'h0;
    go = 1'b0;
    len = 8'h00;
    stall = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (6) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    t_reset;
    t_badsel;
    t_master(3'h2, 4'd7, 56'h0123456789abcd, 1'b0, 8'h00);
    stall = 1'b1;
    t_master(3'h3, 4'd4, 56'h89abcdef, 1'b1, 8'h08);
    t_master(3'h3, 4'd4, 56'h12345678, 1'b0, 8'h00);
    t_master(3'h4, 4'd6, 56'h0123456789ab, 1'b0, 8'h00);
    t_slave(3'h2, {8'h00, 56'h0123456789abcd}, 56'h0123456789abcd);
    t_slave(3'h3, 64'h89abcdef01234567, 56'h89abcdef);
    t_slave(3'h4, {16'h0, 48'h0123456789ab}, 56'h0123456789ab);
    t_term;
    stop_test;
  end
endmodule // mdl_loader_test
